/* File: include/ccp_cfg.svh */
/*
  Holds the register offsets, field positions, reset values and timing
  counts of the capture/compare/PWM channel.
  Assumes it is included by bare name, after the type package is compiled.
*/
`ifndef CCP_CFG_SVH
`define CCP_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// Byte offsets on the Wishbone bus
`define CCP_ADR_CONTROL 8'h00
`define CCP_ADR_CAP_SRC 8'h04
`define CCP_ADR_VAL_LOW 8'h08
`define CCP_ADR_VAL_HIGH 8'h0C
`define CCP_ADR_PERIOD 8'h10
`define CCP_ADR_TIMER_CFG 8'h14
`define CCP_ADR_STATUS 8'h18
`define CCP_ADR_TIMER 8'h1C
`define CCP_ADR_STEPS 8'h20

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define CCP_CTL_EN_BIT 7
`define CCP_CTL_OUT_BIT 5
`define CCP_CTL_FMT_BIT 4
`define CCP_TCFG_ON_BIT 0
`define CCP_TCFG_PRE_LSB 1
`define CCP_TCFG_ADC_BIT 3
`define CCP_TCFG_DRIVE_BIT 4
`define CCP_STAT_FLAG_BIT 0

////////////////////////////////////////////////////////////////////////////////
// Mode codes
`define CCP_MODE_OFF 4'h0
`define CCP_MODE_CMP_TOG_CLR 4'h1
`define CCP_MODE_CMP_TOG 4'h2
`define CCP_MODE_CAP_ANY 4'h3
`define CCP_MODE_CAP_FALL 4'h4
`define CCP_MODE_CAP_RISE 4'h5
`define CCP_MODE_CAP_RISE4 4'h6
`define CCP_MODE_CAP_RISE16 4'h7
`define CCP_MODE_CMP_SET 4'h8
`define CCP_MODE_CMP_CLR 4'h9
`define CCP_MODE_CMP_PULSE 4'hA
`define CCP_MODE_CMP_PULSE_CLR 4'hB
`define CCP_MODE_PWM_FIRST 4'hC

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define CCP_RST_BYTE 8'h00
`define CCP_RST_PERIOD 8'hFF

////////////////////////////////////////////////////////////////////////////////
// Timing: system clocks per instruction cycle, and pulse count load (pulse lasts one clock more)
`define CCP_CLK_PER_INSTR 3'h4
`define CCP_PULSE_CYCLES 2'h3

`endif

/* File: include/ccp_pkg.sv */
/*
  Holds the types shared by the capture/compare/PWM channel files.
  Assumes nothing of its surroundings.
*/
package ccp_pkg;

  // Operating class decoded from the four mode bits
  typedef enum logic [1:0] {
    OP_OFF,
    OP_CAPTURE,
    OP_COMPARE,
    OP_PWM
  } op_t;

endpackage

/* File: rtl/ccp_input_sync.sv */
/*
  Three-stage synchroniser for the eight capture sources.
  Assumes the sources are asynchronous to clk_i; a level is taken once the
  second and third stages agree.
*/
`timescale 1ns/1ps

module ccp_input_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Raw and filtered levels
  input wire logic [7:0] raw_i,
  output logic [7:0] level_o
);

  logic [7:0] stage1;
  logic [7:0] stage2;
  logic [7:0] stage3;
  wire [7:0] agree = ~(stage2 ^ stage3);
  wire [7:0] next_level = (agree & stage3) | (~agree & level_o);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage1 <= 8'h00;
      stage2 <= 8'h00;
      stage3 <= 8'h00;
      level_o <= 8'h00;
    end else begin
      stage1 <= raw_i;
      stage2 <= stage1;
      stage3 <= stage2;
      level_o <= next_level;
    end
  end

endmodule

/* File: rtl/ccp_capture_trigger.sv */
/*
  Edge detector and edge prescaler for the capture modes.
  Assumes a level already synchronised to clk_i; fire_o is combinational.
*/
`timescale 1ns/1ps
`include "ccp_cfg.svh"

module ccp_capture_trigger (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic clear_i,
  input wire logic hold_i,
  input wire logic [3:0] mode_i,
  // Selected level and capture strobe
  input wire logic level_i,
  output logic fire_o
);

  logic prev;
  logic [3:0] rise_cnt;
  wire rise = level_i & ~prev;
  wire fall = ~level_i & prev;
  wire do_rise4 = rise & (rise_cnt[1:0] == 2'h3);
  wire do_rise16 = rise & (rise_cnt == 4'hF);

  assign fire_o = hold_i ? 1'b0 :
                  (mode_i == `CCP_MODE_CAP_ANY) ? (rise | fall) :
                  (mode_i == `CCP_MODE_CAP_FALL) ? fall :
                  (mode_i == `CCP_MODE_CAP_RISE) ? rise :
                  (mode_i == `CCP_MODE_CAP_RISE4) ? do_rise4 :
                  (mode_i == `CCP_MODE_CAP_RISE16) ? do_rise16 :
                  1'b0;

  // Prev keeps tracking while cleared so a stale edge never fires on enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev <= 1'b0;
      rise_cnt <= 4'h0;
    end else if (clear_i) begin
      prev <= level_i;
      rise_cnt <= 4'h0;
    end else if (!hold_i) begin
      prev <= level_i;
      rise_cnt <= rise ? rise_cnt + 4'h1 : rise_cnt;
    end
  end

endmodule

/* File: rtl/cap_cmp_pwm_channel.sv */
/*
  Capture/compare/PWM channel with its period timer and a Wishbone slave.
  Assumes the compare timer runs outside and is cleared by a pulse from here,
  capture sources are asynchronous, and sleep_i comes from logic on clk_i.
*/
`timescale 1ns/1ps
`include "ccp_cfg.svh"

// How it works
// - Duty register pair buffered into working copy
// - Time base is timer plus two bits
// - Prescale one uses system clock phase bits
// - PWM output low at duty match
// - Duty above period never clears output
// - Duty steps follow period value
// - Sleep freezes timer and channel state
// - Reset defaults registers, pin to input
// - Control bit 7 enables channel
// - Bit 5 reads output, bit 6 zero
// - Bit 4 picks duty alignment in PWM
// - Codes 1100 to 1111 select PWM
// - Codes 1011, 1010 pulse output on match
// - Code 1001 clears, 1000 sets output
// - Codes 0111, 0110 capture every sixteenth/fourth rise
// - Codes 0101, 0100, 0011 rise, fall, any
// - Codes 0010 toggle, 0001 toggle and clear
// - Code 0000 turns channel off, resets
// - Every event sets flag, may trigger ADC
// - Three-bit field selects capture source
// - Low value captures or compares timer low
// - Low byte holds duty LSBs per alignment
// - High byte holds duty MSBs per alignment
// - Period wrap clears timer, sets output if duty nonzero, loads
module cap_cmp_pwm_channel (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Power state
  input wire logic sleep_i,
  // Compare timer
  input wire logic [15:0] compare_timer_i,
  output logic compare_timer_clear_o,
  // Capture sources
  input wire logic routed_capture_pin_i,
  input wire logic comparator_one_output_i,
  input wire logic comparator_two_output_i,
  input wire logic pin_change_event_i,
  input wire logic [3:0] logic_cell_output_i,
  // Channel pin and events
  output logic channel_out_o,
  output logic channel_out_oe_n_o,
  output logic channel_event_flag_o,
  output logic adc_trigger_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic ccp_pkg::op_t op_of(input logic [3:0] mode);
    if (mode == `CCP_MODE_OFF) begin
      op_of = ccp_pkg::OP_OFF;
    end else if (mode >= `CCP_MODE_PWM_FIRST) begin
      op_of = ccp_pkg::OP_PWM;
    end else if (mode >= `CCP_MODE_CAP_ANY && mode <= `CCP_MODE_CAP_RISE16) begin
      op_of = ccp_pkg::OP_CAPTURE;
    end else begin
      op_of = ccp_pkg::OP_COMPARE;
    end
  endfunction

  // Prescaler count that ends one timer step: 1, 4, 16 or 64
  function automatic logic pre_done_of(input logic [1:0] sel, input logic [5:0] cnt);
    case (sel)
      2'h0: pre_done_of = 1'b1;
      2'h1: pre_done_of = (cnt[1:0] == 2'h3);
      2'h2: pre_done_of = (cnt[3:0] == 4'hF);
      default: pre_done_of = (cnt == 6'h3F);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic ctl_en;
  logic ctl_fmt;
  logic [3:0] ctl_mode;
  logic [2:0] cap_sel;
  logic [7:0] val_low;
  logic [7:0] val_high;
  logic [7:0] period_value;
  logic tmr_on;
  logic [1:0] pre_sel;
  logic adc_sel;
  logic pin_drive;
  logic event_flag;
  logic out_level;
  logic [7:0] period_timer;
  logic [1:0] phase;
  logic [5:0] pre_cnt;
  logic [9:0] duty_buf;
  logic pulse_active;
  logic [1:0] pulse_cnt;
  logic match_q;
  logic [7:0] src_level;
  logic cap_fire;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  wire wr_ctl = bus_wr & (wb_adr_i == `CCP_ADR_CONTROL);
  wire wr_src = bus_wr & (wb_adr_i == `CCP_ADR_CAP_SRC);
  wire wr_low = bus_wr & (wb_adr_i == `CCP_ADR_VAL_LOW);
  wire wr_high = bus_wr & (wb_adr_i == `CCP_ADR_VAL_HIGH);
  wire wr_per = bus_wr & (wb_adr_i == `CCP_ADR_PERIOD);
  wire wr_tcfg = bus_wr & (wb_adr_i == `CCP_ADR_TIMER_CFG);
  wire wr_stat = bus_wr & (wb_adr_i == `CCP_ADR_STATUS);
  wire [7:0] wdat = wb_dat_i[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode

  ccp_pkg::op_t op;
  assign op = op_of(ctl_mode);
  wire active = ctl_en & (op != ccp_pkg::OP_OFF);
  wire is_cap = active & (op == ccp_pkg::OP_CAPTURE);
  wire is_cmp = active & (op == ccp_pkg::OP_COMPARE);
  wire is_pwm = active & (op == ccp_pkg::OP_PWM);
  wire run = ~sleep_i;

  ////////////////////////////////////////////////////////////////////////////
  // Period timer and 10-bit time base

  wire instr_tick = (phase == 2'(`CCP_CLK_PER_INSTR - 3'h1));
  wire pre_done = pre_done_of(pre_sel, pre_cnt);
  wire timer_inc = run & tmr_on & instr_tick & pre_done;
  wire wrap = timer_inc & (period_timer == period_value);
  wire [1:0] pre_low = (pre_sel == 2'h1) ? pre_cnt[1:0] :
                       (pre_sel == 2'h2) ? pre_cnt[3:2] : pre_cnt[5:4];
  wire [1:0] low2 = (pre_sel == 2'h0) ? phase : pre_low;
  wire [9:0] time_base = {period_timer, low2};
  wire low_step = (pre_sel == 2'h0) | (instr_tick & ((pre_sel == 2'h1) |
                  ((pre_sel == 2'h2) & (pre_cnt[1:0] == 2'h3)) | (pre_cnt[3:0] == 4'hF)));
  // Distinct duty steps in one period, shown to software
  wire [10:0] duty_steps = {1'b0, period_value, 2'h0} + 11'h004;

  ////////////////////////////////////////////////////////////////////////////
  // Duty value and PWM events

  wire [9:0] duty_reg = ctl_fmt ? {val_high, val_low[7:6]} :
                                  {val_high[1:0], val_low};
  // Duty above the period never equals the time base, so no clear
  // Match on the step into the duty value so the pin drops on time
  wire pwm_step = is_pwm & run & tmr_on & low_step & out_level;
  wire pwm_hit = pwm_step & (wrap ? (duty_reg == 10'h000) : (10'(time_base + 10'h001) == duty_buf));
  wire pwm_set = is_pwm & wrap & (duty_reg != 10'h000);

  ////////////////////////////////////////////////////////////////////////////
  // Compare and capture events

  wire cmp_match = (compare_timer_i == {val_high, val_low});
  wire cmp_hit = is_cmp & run & cmp_match & ~match_q;
  wire cmp_clr_mode = (ctl_mode == `CCP_MODE_CMP_TOG_CLR) | (ctl_mode == `CCP_MODE_CMP_PULSE_CLR);
  wire cmp_pulse_mode = (ctl_mode == `CCP_MODE_CMP_PULSE) | (ctl_mode == `CCP_MODE_CMP_PULSE_CLR);
  wire cmp_clear = cmp_hit & cmp_clr_mode;
  wire pulse_start = cmp_hit & cmp_pulse_mode;
  wire pulse_end = pulse_active & run & (pulse_cnt == 2'h0);
  wire cap_hit = is_cap & cap_fire;
  wire any_event = cap_hit | cmp_hit | pwm_hit;

  wire cmp_out = (ctl_mode == `CCP_MODE_CMP_SET) ? 1'b1 :
                 (ctl_mode == `CCP_MODE_CMP_CLR) ? 1'b0 :
                 cmp_pulse_mode ? 1'b1 :
                 ~out_level;
  wire next_out = !active ? 1'b0 :
                  pulse_end ? 1'b0 :
                  cmp_hit ? cmp_out :
                  pwm_set ? 1'b1 :
                  pwm_hit ? 1'b0 :
                  out_level;

  ////////////////////////////////////////////////////////////////////////////
  // Capture source path

  wire [7:0] src_raw = {logic_cell_output_i, pin_change_event_i, comparator_two_output_i,
                        comparator_one_output_i, routed_capture_pin_i};
  wire cap_level = src_level[cap_sel];

  ccp_input_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i(src_raw),
    .level_o(src_level)
  );

  ccp_capture_trigger u_trig (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(~is_cap),
    .hold_i(sleep_i),
    .mode_i(ctl_mode),
    .level_i(cap_level),
    .fire_o(cap_fire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  wire [7:0] ctl_rd = {ctl_en, 1'b0, out_level, ctl_fmt, ctl_mode};
  wire [7:0] tcfg_rd = {3'h0, pin_drive, adc_sel, pre_sel, tmr_on};
  wire [31:0] rd_data = (wb_adr_i == `CCP_ADR_CONTROL) ? {24'h000000, ctl_rd} :
                        (wb_adr_i == `CCP_ADR_CAP_SRC) ? {29'h00000000, cap_sel} :
                        (wb_adr_i == `CCP_ADR_VAL_LOW) ? {24'h000000, val_low} :
                        (wb_adr_i == `CCP_ADR_VAL_HIGH) ? {24'h000000, val_high} :
                        (wb_adr_i == `CCP_ADR_PERIOD) ? {24'h000000, period_value} :
                        (wb_adr_i == `CCP_ADR_TIMER_CFG) ? {24'h000000, tcfg_rd} :
                        (wb_adr_i == `CCP_ADR_STATUS) ? {31'h00000000, event_flag} :
                        (wb_adr_i == `CCP_ADR_TIMER) ? {24'h000000, period_timer} :
                        (wb_adr_i == `CCP_ADR_STEPS) ? {21'h000000, duty_steps} :
                        32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_data : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  // Bit 5 is not stored from the bus; bit 6 is not stored at all
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_en <= 1'b0;
      ctl_fmt <= 1'b0;
      ctl_mode <= `CCP_MODE_OFF;
      cap_sel <= 3'h0;
      period_value <= `CCP_RST_PERIOD;
    end else begin
      if (wr_ctl) begin
        ctl_en <= wdat[`CCP_CTL_EN_BIT];
        ctl_fmt <= wdat[`CCP_CTL_FMT_BIT];
        ctl_mode <= wdat[3:0];
      end
      if (wr_src) begin
        cap_sel <= wdat[2:0];
      end
      if (wr_per) begin
        period_value <= wdat;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_on <= 1'b0;
      pre_sel <= 2'h0;
      adc_sel <= 1'b0;
      pin_drive <= 1'b0;
    end else if (wr_tcfg) begin
      tmr_on <= wdat[`CCP_TCFG_ON_BIT];
      pre_sel <= wdat[`CCP_TCFG_PRE_LSB +: 2];
      adc_sel <= wdat[`CCP_TCFG_ADC_BIT];
      pin_drive <= wdat[`CCP_TCFG_DRIVE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Value register pair

  // A capture wins over a bus write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      val_low <= `CCP_RST_BYTE;
      val_high <= `CCP_RST_BYTE;
    end else if (cap_hit) begin
      val_low <= compare_timer_i[7:0];
      val_high <= compare_timer_i[15:8];
    end else begin
      if (wr_low) begin
        val_low <= wdat;
      end
      if (wr_high) begin
        val_high <= wdat;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Period timer and working duty copy

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase <= 2'h0;
      pre_cnt <= 6'h00;
      period_timer <= 8'h00;
      duty_buf <= 10'h000;
    end else if (run) begin
      phase <= phase + 2'h1;
      if (tmr_on & instr_tick) begin
        pre_cnt <= pre_done ? 6'h00 : pre_cnt + 6'h01;
      end
      if (wrap) begin
        period_timer <= 8'h00;
        duty_buf <= duty_reg;
      end else if (timer_inc) begin
        period_timer <= period_timer + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel output, pulse timing and events

  always_ff @(posedge clk_i) begin
    if (rst_i || !active) begin
      out_level <= 1'b0;
      pulse_active <= 1'b0;
      pulse_cnt <= 2'h0;
      match_q <= 1'b0;
    end else if (run) begin
      out_level <= next_out;
      match_q <= cmp_match;
      if (pulse_start) begin
        pulse_active <= 1'b1;
        pulse_cnt <= `CCP_PULSE_CYCLES;
      end else if (pulse_end) begin
        pulse_active <= 1'b0;
      end else if (pulse_active) begin
        pulse_cnt <= pulse_cnt - 2'h1;
      end
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_flag <= 1'b0;
      adc_trigger_o <= 1'b0;
      compare_timer_clear_o <= 1'b0;
      channel_out_oe_n_o <= 1'b1;
    end else begin
      event_flag <= any_event | (event_flag & ~(wr_stat & wdat[`CCP_STAT_FLAG_BIT]));
      adc_trigger_o <= any_event & adc_sel;
      compare_timer_clear_o <= cmp_clear;
      channel_out_oe_n_o <= ~(pin_drive & ctl_en);
    end
  end

  assign channel_out_o = out_level;
  assign channel_event_flag_o = event_flag;

endmodule

/* File: sim/ccp_port_sva.sv */
/*
  Port checker for the capture/compare/PWM channel.
  Assumes one clock, synchronous active-high reset, bound to the top module.
*/
`timescale 1ns/1ps
`include "ccp_cfg.svh"

module ccp_port_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Channel
  input wire logic sleep_i,
  input wire logic compare_timer_clear_o,
  input wire logic channel_out_o,
  input wire logic channel_out_oe_n_o,
  input wire logic channel_event_flag_o,
  input wire logic adc_trigger_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic flag_wr = req && wb_we_i && wb_adr_i == `CCP_ADR_STATUS && wb_sel_i[0] && wb_dat_i[0];
  ////////////////////////////////////////////////////////////////////////////
  ack_follows_a: assert property (req |=> wb_ack_o) else $error("request left without ack");
  stray_ack_a: assert property (!req |=> !wb_ack_o) else $error("ack without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  reset_state_a: assert property ($fell(rst_i) |-> !wb_ack_o && channel_out_oe_n_o && !channel_out_o
    && !channel_event_flag_o && !adc_trigger_o && !compare_timer_clear_o) else $error("bad reset state");
  clear_pulse_a: assert property (compare_timer_clear_o |=> !compare_timer_clear_o)
    else $error("timer clear longer than one cycle");
  clear_flag_a: assert property (compare_timer_clear_o |-> channel_event_flag_o)
    else $error("timer clear without event flag");
  adc_pulse_a: assert property (adc_trigger_o |=> !adc_trigger_o) else $error("trigger too long");
  adc_flag_a: assert property (adc_trigger_o |-> channel_event_flag_o) else $error("trigger without flag");
  flag_sticky_a: assert property ($fell(channel_event_flag_o) |-> $past(flag_wr))
    else $error("event flag dropped without clear");
  sleep_hold_a: assert property (sleep_i && !wb_stb_i |=> $stable(channel_out_o))
    else $error("output moved in sleep");
endmodule

bind cap_cmp_pwm_channel ccp_port_sva chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_i(sleep_i), .compare_timer_clear_o(compare_timer_clear_o),
  .channel_out_o(channel_out_o), .channel_out_oe_n_o(channel_out_oe_n_o),
  .channel_event_flag_o(channel_event_flag_o), .adc_trigger_o(adc_trigger_o));

/* File: sim/ccp_far_side.sv */
/*
  Compare timer model on the far side of the channel.
  Assumes the bench may hold it at a value; clear pulses come from the channel.
*/
`timescale 1ns/1ps

module ccp_far_side (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic sleep_i,
  input wire logic clear_i,
  input wire logic load_i,
  input wire logic [15:0] load_val_i,
  // Timer value
  output logic [15:0] timer_o
);
  logic [15:0] count;
  assign timer_o = count;
  // Counts every clock outside sleep; a held load keeps matches away during setup
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      count <= 16'h0000;
    end else if (load_i) begin
      count <= load_val_i;
    end else if (!sleep_i) begin
      count <= count + 16'h0001;
    end
  end
endmodule

/* File: sim/cap_cmp_pwm_channel_bench.sv */
/*
  Self-checking bench for the capture/compare/PWM channel.
  Assumes the far-side timer model and the bound port checker.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module cap_cmp_pwm_channel_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, exp_v;
  logic wb_ack_o, clr, out, oe_n, flag, adc, out_q;
  logic sleep_i = 1'b0;
  logic tmr_load = 1'b1;
  logic [15:0] tmr;
  logic [15:0] tmr_val = 16'h0000;
  logic [7:0] src = 8'h00;
  logic [31:0] expq[$];
  int mismatches = 0, num_checks = 0, cycles = 0, n_clr, n_adc, n_hi, n_chg;
  logic [7:0] rst_adr [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'hFC};
  logic [31:0] rst_exp [10] = '{0, 0, 0, 0, 32'hFF, 0, 0, 0, 32'h400, 0};
  logic [3:0] cmp_mode [6] = '{4'h8, 4'h9, 4'h1, 4'h2, 4'hA, 4'hB};
  logic cmp_out [6] = '{1, 0, 1, 1, 0, 0};
  int cmp_clr [6] = '{0, 0, 1, 0, 0, 1};
  logic [3:0] cap_mode [8] = '{4'h5, 4'h4, 4'h3, 4'h6, 4'h7, 4'h5, 4'h5, 4'h5};
  int cap_n [8] = '{1, 1, 1, 4, 16, 1, 1, 1};
  logic pwm_fmt [4] = '{0, 1, 0, 0};
  logic [7:0] pwm_hi [4] = '{8'h00, 8'h02, 8'h01, 8'h00};
  logic [7:0] pwm_lo [4] = '{8'h00, 8'h40, 8'h04, 8'h06};
  int pwm_cnt [4] = '{0, 36, 64, 24};

  always #5 clk_i = ~clk_i;

  cap_cmp_pwm_channel dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sleep_i(sleep_i), .compare_timer_i(tmr), .compare_timer_clear_o(clr),
    .routed_capture_pin_i(src[0]), .comparator_one_output_i(src[1]), .comparator_two_output_i(src[2]),
    .pin_change_event_i(src[3]), .logic_cell_output_i(src[7:4]), .channel_out_o(out),
    .channel_out_oe_n_o(oe_n), .channel_event_flag_o(flag), .adc_trigger_o(adc));

  ccp_far_side far (.clk_i(clk_i), .rst_i(rst_i), .sleep_i(sleep_i), .clear_i(clr), .load_i(tmr_load),
    .load_val_i(tmr_val), .timer_o(tmr));

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Monitor: read answers against the oldest note, plus event counters
  always @(posedge clk_i) begin
    cycles++;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expq.size() > 0) begin
      exp_v = expq.pop_front();
      `CHK(wb_dat_o, exp_v)
    end
    n_clr += int'(clr);
    n_adc += int'(adc);
    n_hi += int'(out);
    n_chg += int'(out !== out_q);
    out_q = out;
    if (cycles == 10000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'($urandom), d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask

  // Counts over exactly n edges, read after they settle
  task automatic run(input int n);
    @(negedge clk_i);
    n_clr = 0;
    n_adc = 0;
    n_hi = 0;
    n_chg = 0;
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic pulse(input int k);
    @(posedge clk_i);
    src[k] <= 1'b1;
    repeat (8) @(posedge clk_i);
    src[k] <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hC2CD));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rst_adr[i]) rd(rst_adr[i], rst_exp[i]);
    wr(8'h00, 8'h7C);
    rd(8'h00, 32'h1C);
    wr(8'h04, 8'hFF);
    rd(8'h04, 32'h07);
    wr(8'hFC, 8'h5A);
    rd(8'hFC, 32'h0);
    $display("test registers done");
    wr(8'h14, 8'h18);
    wr(8'h08, 8'h40);
    wr(8'h0C, 8'h00);
    foreach (cmp_mode[i]) begin
      wr(8'h00, 8'h00);
      wr(8'h18, 8'h01);
      rd(8'h18, 32'h0);
      `CHK(out, 1'b0)
      wr(8'h00, {4'h8, cmp_mode[i]});
      @(posedge clk_i);
      tmr_load <= 1'b0;
      run(100);
      tmr_load <= 1'b1;
      `CHK(oe_n, 1'b0)
      `CHK(n_clr, cmp_clr[i])
      `CHK(n_adc, 1)
      rd(8'h00, {24'h0, 2'b10, cmp_out[i], 1'b0, cmp_mode[i]});
      rd(8'h18, 32'h1);
      if (cmp_mode[i][3:1] == 3'b101) `CHK(n_hi, 4)
    end
    $display("test compare done");
    foreach (cap_mode[i]) begin
      tmr_val <= 16'($urandom);
      wr(8'h00, 8'h00);
      wr(8'h04, {5'h0, 3'(i)});
      wr(8'h18, 8'h01);
      wr(8'h00, {4'h8, cap_mode[i]});
      repeat (cap_n[i] - 1) pulse(i);
      rd(8'h18, 32'h0);
      pulse(i);
      rd(8'h18, 32'h1);
      rd(8'h08, {24'h0, tmr_val[7:0]});
      rd(8'h0C, {24'h0, tmr_val[15:8]});
    end
    $display("test capture done");
    wr(8'h00, 8'h00);
    wr(8'h10, 8'h03);
    rd(8'h20, 32'h10);
    wr(8'h14, 8'h19);
    foreach (pwm_lo[i]) begin
      wr(8'h00, {3'b100, pwm_fmt[i], 4'hC + 4'(i)});
      wr(8'h0C, pwm_hi[i]);
      wr(8'h08, pwm_lo[i]);
      run(48);
      run(64);
      `CHK(n_hi, pwm_cnt[i])
    end
    @(posedge clk_i);
    sleep_i <= 1'b1;
    @(posedge clk_i);
    run(40);
    `CHK(n_chg, 0)
    @(posedge clk_i);
    sleep_i <= 1'b0;
    run(64);
    `CHK(n_hi, 24)
    wr(8'h14, 8'h1B);
    run(128);
    run(128);
    `CHK(n_hi, 48)
    $display("test pwm done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h10, 32'hFF);
    `CHK(oe_n, 1'b1)
    $display("test reset done");
    summarize();
  end
endmodule
